/* File: fspc_pkg.sv */
// Shared constants and carrier types for the flash self-program controller.
// Assumes one CPU clock domain; every user of these names writes fspc_pkg::name.
package fspc_pkg;

	// Register map and field positions
	localparam logic [7:0] CTRL_OFFSET = 8'h00;
	localparam logic [7:0] CTRL_RESET = 8'h00;
	localparam logic [7:0] UNMAPPED_READ = 8'h00;
	localparam int BIT_READY_IE = 7;
	localparam int BIT_BUSY = 6;
	localparam int BIT_RESERVED = 5;
	localparam int BIT_SECT_RE = 4;
	localparam int BIT_LOCK_SET = 3;
	localparam int BIT_PAGE_WR = 2;
	localparam int BIT_PAGE_ER = 1;
	localparam int BIT_STORE_EN = 0;

	// Idle value and accepted five-bit command patterns in the low control bits
	localparam logic [4:0] CMD_NONE = 5'h00;
	localparam logic [4:0] CMD_REENABLE = 5'h11;
	localparam logic [4:0] CMD_LOCK = 5'h09;
	localparam logic [4:0] CMD_WRITE = 5'h05;
	localparam logic [4:0] CMD_ERASE = 5'h03;
	localparam logic [4:0] CMD_STORE = 5'h01;

	// Arming windows in CPU clock cycles
	localparam logic [2:0] ARM_CYCLES = 3'h4;
	localparam logic [2:0] LPM_CYCLES = 3'h3;
	localparam logic [2:0] CNT_ZERO = 3'h0;
	localparam logic [2:0] CNT_ONE = 3'h1;

	// Addressing
	localparam int PTR_W = 16;
	localparam logic [15:0] APP_RESET_ADDR = 16'h0000;
	localparam logic [1:0] SEL_FUSE_LOW = 2'h0;
	localparam logic [1:0] SEL_LOCK = 2'h1;
	localparam logic [1:0] SEL_FUSE_HIGH = 2'h3;

	// Flash array operation kinds
	localparam logic [1:0] OP_ERASE = 2'h0;
	localparam logic [1:0] OP_WRITE = 2'h1;
	localparam logic [1:0] OP_LOCK = 2'h2;

	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_ARMED = 3'b010,
		ST_BUSY = 3'b100
	} fspc_state_t;

	// One CPU program-memory instruction slot
	typedef struct packed {
		logic store_program_instruction;
		logic lpm;
		logic [15:0] pointer;
		logic [7:0] data_low;
		logic [7:0] data_high;
	} fspc_cpu_req_t;

	// Command to the flash array
	typedef struct packed {
		logic start;
		logic [1:0] kind;
		logic [15:0] page;
		logic [7:0] lock_data;
	} fspc_flash_op_t;

endpackage

/* File: fspc_page_buf.sv */
// Temporary page buffer: one word per page slot, random-order writes.
// Assumes a single clock; clear empties the whole buffer in one cycle.
`timescale 1ns/1ps
module fspc_page_buf #(
	parameter int AW = 5,
	parameter int DW = 16
) (
	input wire logic clock,
	input wire logic srst,
	input wire logic clear,
	input wire logic wr_en,
	input wire logic [AW-1:0] wr_addr,
	input wire logic [DW-1:0] wr_data,
	input wire logic [AW-1:0] rd_addr,
	output logic [DW-1:0] rd_data
);
	localparam int DEPTH = 1 << AW;
	localparam logic [DW-1:0] ERASED = {DW{1'b1}};

	logic [DW-1:0] mem_r [DEPTH];
	logic [DEPTH-1:0] valid_r;
	logic [DW-1:0] rd_data_r;

	// Valid bits stand in for a full wipe; unwritten slots read as erased
	always_ff @(posedge clock)
	begin
		if (srst || clear)
			valid_r <= '0;
		else if (wr_en)
			valid_r[wr_addr] <= 1'b1;
	end

	// Storage itself needs no reset
	always_ff @(posedge clock)
	begin
		if (wr_en)
			mem_r[wr_addr] <= wr_data;
	end

	// Registered read port
	always_ff @(posedge clock)
	begin
		if (srst)
			rd_data_r <= ERASED;
		else
			rd_data_r <= valid_r[rd_addr] ? mem_r[rd_addr] : ERASED;
	end

	assign rd_data = rd_data_r;
endmodule // fspc_page_buf

/* File: fspc_ctrl.sv */
// Flash self-program controller: control register, arming windows, page
// buffer fill, erase/write/lock sequencing and fuse/lock readback.
// Assumes CPU, flash array and fuse store all run on clock.
`timescale 1ns/1ps
module fspc_ctrl #(
	parameter int PAGE_WORD_BITS = 5,
	parameter logic [15:0] BLOCKING_FIRST_PAGE = 16'h0060,
	parameter logic [15:0] BOOT_START_ADDR = 16'h0C00
) (
	input wire logic clock,
	input wire logic srst,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	input wire fspc_pkg::fspc_cpu_req_t cpu_req,
	input wire logic global_int_flag,
	input wire logic eeprom_busy,
	output logic ready_irq,
	output logic cpu_stall,
	output logic lpm_valid,
	output logic [7:0] lpm_data,
	output logic section_blocked,
	output logic [15:0] reset_vector,
	input wire logic boot_reset_fuse,
	input wire logic [7:0] fuse_low,
	input wire logic [7:0] fuse_high,
	input wire logic [7:0] lock_bits,
	output fspc_pkg::fspc_flash_op_t flash_op,
	input wire logic flash_done,
	input wire logic [PAGE_WORD_BITS-1:0] flash_buf_addr,
	output logic [15:0] flash_buf_data
);
	fspc_pkg::fspc_state_t state_r, state_nxt;
	logic [4:0] cmd_r, cmd_nxt;
	logic [2:0] cnt_r, cnt_nxt;
	logic ie_r;
	logic busy_flag_r, busy_flag_nxt;
	logic blocking_r;
	fspc_pkg::fspc_flash_op_t op_r, op_nxt;
	logic [7:0] rdata_r;
	logic lpm_valid_r;
	logic [7:0] lpm_data_r;
	logic [15:0] reset_vector_r;

	// Register decode
	wire ctrl_hit = (reg_addr == fspc_pkg::CTRL_OFFSET);
	wire wr_ctrl = reg_wr && ctrl_hit;
	wire [4:0] wr_pattern = reg_wdata[4:0];
	wire is_idle = (state_r == fspc_pkg::ST_IDLE);
	wire is_armed = (state_r == fspc_pkg::ST_ARMED);
	wire is_busy = (state_r == fspc_pkg::ST_BUSY);

	// Pattern filter; anything else is dropped
	wire pattern_ok = (wr_pattern == fspc_pkg::CMD_REENABLE) ||
		(wr_pattern == fspc_pkg::CMD_LOCK) ||
		(wr_pattern == fspc_pkg::CMD_WRITE) ||
		(wr_pattern == fspc_pkg::CMD_ERASE) ||
		(wr_pattern == fspc_pkg::CMD_STORE);
	// No arming while the array is busy or an EEPROM write runs
	wire accept_arm = wr_ctrl && pattern_ok && !is_busy && !eeprom_busy;

	// Armed command decode
	wire cmd_store = (cmd_r == fspc_pkg::CMD_STORE);
	wire cmd_erase = (cmd_r == fspc_pkg::CMD_ERASE);
	wire cmd_write = (cmd_r == fspc_pkg::CMD_WRITE);
	wire cmd_lock = (cmd_r == fspc_pkg::CMD_LOCK);
	wire cmd_reen = (cmd_r == fspc_pkg::CMD_REENABLE);

	// A store counts only inside the arming window
	wire spm_go = cpu_req.store_program_instruction && is_armed && !eeprom_busy;
	wire start_page = spm_go && (cmd_erase || cmd_write);
	wire start_op = start_page || (spm_go && cmd_lock);
	wire lpm_hit = cpu_req.lpm && is_armed && cmd_lock &&
		(cnt_r < fspc_pkg::LPM_CYCLES) && !eeprom_busy;
	wire timeout = is_armed && (cnt_r == fspc_pkg::ARM_CYCLES - fspc_pkg::CNT_ONE) &&
		!spm_go && !lpm_hit && !accept_arm;

	// Pointer split: byte select, word in page, page number
	wire [PAGE_WORD_BITS-1:0] word_idx = cpu_req.pointer[PAGE_WORD_BITS:1];
	wire [15:0] ptr_page = 16'(cpu_req.pointer >> (PAGE_WORD_BITS + 1));
	wire page_blocking = (ptr_page >= BLOCKING_FIRST_PAGE);

	// Buffer control; read-enable write wipes a partial load
	wire buf_we = spm_go && cmd_store;
	wire buf_clear = (wr_ctrl && reg_wdata[fspc_pkg::BIT_SECT_RE]) ||
		(spm_go && cmd_reen) ||
		(is_busy && flash_done && (op_r.kind == fspc_pkg::OP_WRITE));

	fspc_page_buf #(
		.AW(PAGE_WORD_BITS),
		.DW(16)
	) u_page_buf (
		.clock(clock),
		.srst(srst),
		.clear(buf_clear),
		.wr_en(buf_we),
		.wr_addr(word_idx),
		.wr_data({cpu_req.data_high, cpu_req.data_low}),
		.rd_addr(flash_buf_addr),
		.rd_data(flash_buf_data)
	);

	// Sequencer: idle, armed window, array busy
	always_comb
	begin
		state_nxt = state_r;
		cmd_nxt = cmd_r;
		cnt_nxt = cnt_r;
		case (state_r)
			fspc_pkg::ST_IDLE:
			begin
				if (accept_arm)
				begin
					state_nxt = fspc_pkg::ST_ARMED;
					cmd_nxt = wr_pattern;
					cnt_nxt = fspc_pkg::CNT_ZERO;
				end
			end
			fspc_pkg::ST_ARMED:
			begin
				if (start_op)
					state_nxt = fspc_pkg::ST_BUSY;
				else if (spm_go || lpm_hit || timeout)
				begin
					state_nxt = fspc_pkg::ST_IDLE;
					cmd_nxt = fspc_pkg::CMD_NONE;
				end
				else if (accept_arm)
				begin
					cmd_nxt = wr_pattern;
					cnt_nxt = fspc_pkg::CNT_ZERO;
				end
				else
					cnt_nxt = cnt_r + fspc_pkg::CNT_ONE;
			end
			fspc_pkg::ST_BUSY:
			begin
				// Store enable and command bits held until the array reports done
				if (flash_done)
				begin
					state_nxt = fspc_pkg::ST_IDLE;
					cmd_nxt = fspc_pkg::CMD_NONE;
				end
			end
			default:
			begin
				state_nxt = fspc_pkg::ST_IDLE;
				cmd_nxt = fspc_pkg::CMD_NONE;
				cnt_nxt = fspc_pkg::CNT_ZERO;
			end
		endcase
	end

	always_ff @(posedge clock)
	begin
		if (srst)
		begin
			state_r <= fspc_pkg::ST_IDLE;
			cmd_r <= fspc_pkg::CMD_NONE;
			cnt_r <= fspc_pkg::CNT_ZERO;
		end
		else
		begin
			state_r <= state_nxt;
			cmd_r <= cmd_nxt;
			cnt_r <= cnt_nxt;
		end
	end

	// Interrupt enable is writable at any time, even while busy
	always_ff @(posedge clock)
	begin
		if (srst)
			ie_r <= fspc_pkg::CTRL_RESET[fspc_pkg::BIT_READY_IE];
		else if (wr_ctrl)
			ie_r <= reg_wdata[fspc_pkg::BIT_READY_IE];
	end

	// Section busy: set by a concurrent-section erase/write; set wins over clear
	wire busy_set = start_page && !page_blocking;
	wire busy_clr = spm_go && (cmd_store || cmd_reen);
	assign busy_flag_nxt = busy_set || (busy_flag_r && !busy_clr);

	always_ff @(posedge clock)
	begin
		if (srst)
			busy_flag_r <= fspc_pkg::CTRL_RESET[fspc_pkg::BIT_BUSY];
		else
			busy_flag_r <= busy_flag_nxt;
	end

	// Operation latch; page frozen at start so the pointer is free afterwards
	always_comb
	begin
		op_nxt = op_r;
		op_nxt.start = 1'b0;
		if (start_op)
		begin
			op_nxt.start = 1'b1;
			op_nxt.kind = cmd_lock ? fspc_pkg::OP_LOCK :
				(cmd_write ? fspc_pkg::OP_WRITE : fspc_pkg::OP_ERASE);
			// Lock setting ignores pointer and high data
			op_nxt.page = cmd_lock ? op_r.page : ptr_page;
			op_nxt.lock_data = cpu_req.data_low;
		end
	end

	always_ff @(posedge clock)
	begin
		if (srst)
		begin
			op_r <= '0;
			blocking_r <= 1'b0;
		end
		else
		begin
			op_r <= op_nxt;
			if (start_op)
				blocking_r <= start_page && page_blocking;
		end
	end

	// Stall covers the whole blocking-section operation
	assign cpu_stall = is_busy && blocking_r;
	assign flash_op = op_r;
	assign section_blocked = busy_flag_r;

	// Ready interrupt is a level, not a pulse
	assign ready_irq = ie_r && global_int_flag && !cmd_r[fspc_pkg::BIT_STORE_EN];

	// Control view; reserved bit tied low
	wire [7:0] ctrl_view = {ie_r, busy_flag_r, 1'b0, cmd_r};

	always_ff @(posedge clock)
	begin
		if (srst)
			rdata_r <= fspc_pkg::UNMAPPED_READ;
		else if (reg_rd && ctrl_hit)
			rdata_r <= ctrl_view;
		else
			rdata_r <= fspc_pkg::UNMAPPED_READ;
	end
	assign reg_rdata = rdata_r;

	// Readback select by low pointer bits; raw values, zero means programmed
	wire [1:0] rd_sel = cpu_req.pointer[1:0];
	wire [7:0] rd_pick = (rd_sel == fspc_pkg::SEL_LOCK) ? lock_bits :
		((rd_sel == fspc_pkg::SEL_FUSE_HIGH) ? fuse_high : fuse_low);

	always_ff @(posedge clock)
	begin
		if (srst)
		begin
			lpm_valid_r <= 1'b0;
			lpm_data_r <= fspc_pkg::UNMAPPED_READ;
		end
		else
		begin
			lpm_valid_r <= lpm_hit;
			if (lpm_hit)
				lpm_data_r <= rd_pick;
		end
	end
	assign lpm_valid = lpm_valid_r;
	assign lpm_data = lpm_data_r;

	// Reset vector taken from the fuse during reset; fuses are inputs only
	always_ff @(posedge clock)
	begin
		if (srst)
			reset_vector_r <= boot_reset_fuse ? fspc_pkg::APP_RESET_ADDR : BOOT_START_ADDR;
	end
	assign reset_vector = reset_vector_r;

	// Checks
	a_arm_timeout: assert property (@(posedge clock) disable iff (srst)
		(is_armed && !cpu_req.store_program_instruction && !cpu_req.lpm && !wr_ctrl) [*4] |=> is_idle)
		else $error("store enable outlived its window");
	a_busy_hold: assert property (@(posedge clock) disable iff (srst)
		is_busy && !flash_done |=> cmd_r[fspc_pkg::BIT_STORE_EN])
		else $error("store enable dropped during operation");
	a_stall_blocking: assert property (@(posedge clock) disable iff (srst)
		start_page && page_blocking |=> cpu_stall throughout (is_busy [*1]))
		else $error("no stall for blocking section");
	a_page_latched: assert property (@(posedge clock) disable iff (srst)
		is_busy && $past(is_busy) |-> $stable(op_r.page))
		else $error("page changed mid operation");
	a_reserved_zero: assert property (@(posedge clock) disable iff (srst)
		$past(reg_rd) |-> !reg_rdata[fspc_pkg::BIT_RESERVED])
		else $error("reserved bit read as one");
	a_unarmed_store: assert property (@(posedge clock) disable iff (srst)
		cpu_req.store_program_instruction && !is_armed |=> !flash_op.start)
		else $error("unarmed store had an effect");
	a_busy_set: assert property (@(posedge clock) disable iff (srst)
		start_page && !page_blocking |=> section_blocked ##1 !cpu_stall)
		else $error("section busy not set");
	a_lpm_answer: assert property (@(posedge clock) disable iff (srst)
		lpm_hit |=> lpm_valid && (lpm_data == $past(rd_pick)) && is_idle)
		else $error("readback not delivered");
	a_eeprom_block: assert property (@(posedge clock) disable iff (srst)
		eeprom_busy |=> !flash_op.start && !lpm_valid)
		else $error("activity during eeprom write");
	a_ready_irq: assert property (@(posedge clock) disable iff (srst)
		ie_r && global_int_flag |-> (ready_irq == is_idle))
		else $error("ready interrupt not tied to store enable");
	a_lpm_late: assert property (@(posedge clock) disable iff (srst)
		cpu_req.lpm && is_armed && cmd_lock && (cnt_r >= fspc_pkg::LPM_CYCLES) |=> !lpm_valid)
		else $error("late readback was answered");
	a_pattern_drop: assert property (@(posedge clock) disable iff (srst)
		wr_ctrl && !pattern_ok && is_idle |=> is_idle)
		else $error("invalid pattern armed a store");
endmodule // fspc_ctrl

/* File: fspc_flash_model.sv */
// Flash array stand-in: answers every started operation after a set latency.
// Assumes the controller's flash_op and buffer read port share its clock.
`timescale 1ns/1ps
module fspc_flash_model (
	input wire logic clock,
	input wire logic srst,
	input wire fspc_pkg::fspc_flash_op_t flash_op,
	input wire logic [7:0] latency,
	input wire logic [4:0] buf_sel,
	output logic flash_done,
	output logic [4:0] flash_buf_addr
);
	logic busy_r;
	logic [7:0] cnt_r;
	logic done_r;

	// Buffer word picked by the bench, passed straight through
	assign flash_buf_addr = buf_sel;
	assign flash_done = done_r;

	// Latency count; done only ever follows a start, like the real array
	always_ff @(posedge clock)
	begin
		done_r <= 1'h0;
		if (srst)
		begin
			busy_r <= 1'h0;
			cnt_r <= 8'h00;
		end
		else if (flash_op.start)
		begin
			busy_r <= 1'h1;
			cnt_r <= latency;
		end
		else if (busy_r && cnt_r == 8'h00)
		begin
			busy_r <= 1'h0;
			done_r <= 1'h1;
		end
		else if (busy_r)
			cnt_r <= cnt_r - 8'h01;
	end
endmodule // fspc_flash_model

/* File: testbench.sv */
// Self-checking bench for the flash self-program controller.
// Assumes the flash model answers on flash_done; bench plays the CPU.
`timescale 1ns/1ps
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin miscompares++; \
	$display("mismatch at %0t: got %h want %h", $time, (a), (b)); end end
module testbench;
	localparam logic [7:0] CTRL = fspc_pkg::CTRL_OFFSET;
	logic clock = 1'h0;
	logic srst = 1'h1;
	logic [7:0] reg_addr = 8'h00;
	logic [7:0] reg_wdata = 8'h00;
	logic reg_wr = 1'h0;
	logic reg_rd = 1'h0;
	fspc_pkg::fspc_cpu_req_t cpu_req = '0;
	logic global_int_flag = 1'h0;
	logic eeprom_busy = 1'h0;
	logic boot_reset_fuse = 1'h1;
	logic [7:0] fuse_low = 8'hA6;
	logic [7:0] fuse_high = 8'h5C;
	logic [7:0] lock_bits = 8'h3F;
	logic [7:0] latency = 8'h14;
	logic [4:0] buf_sel = 5'h00;
	logic [7:0] reg_rdata;
	logic [7:0] lpm_data;
	logic ready_irq;
	logic cpu_stall;
	logic lpm_valid;
	logic section_blocked;
	logic flash_done;
	logic [15:0] reset_vector;
	logic [15:0] flash_buf_data;
	logic [4:0] flash_buf_addr;
	fspc_pkg::fspc_flash_op_t flash_op;
	int checked = 0;
	int miscompares = 0;
	logic [7:0] d;

	fspc_ctrl DUT (.clock, .srst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
		.cpu_req, .global_int_flag, .eeprom_busy, .ready_irq, .cpu_stall, .lpm_valid,
		.lpm_data, .section_blocked, .reset_vector, .boot_reset_fuse, .fuse_low,
		.fuse_high, .lock_bits, .flash_op, .flash_done, .flash_buf_addr, .flash_buf_data);
	fspc_flash_model flash (.clock, .srst, .flash_op, .latency, .buf_sel, .flash_done,
		.flash_buf_addr);

	// 25 MHz clock
	always #20 clock = ~clock;

	// Register bus: one-cycle strobes, read data in the following cycle only
	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		@(posedge clock);
		reg_addr <= a;
		reg_wdata <= v;
		reg_wr <= 1'h1;
		@(posedge clock);
		reg_wr <= 1'h0;
	endtask
	task automatic rd(input logic [7:0] a);
		@(posedge clock);
		reg_addr <= a;
		reg_rd <= 1'h1;
		@(posedge clock);
		reg_rd <= 1'h0;
		#1 d = reg_rdata;
	endtask

	// One store (s=1) or load (s=0) instruction slot
	task automatic ins(input logic s, input logic [15:0] p, input logic [15:0] w);
		cpu_req.pointer <= p;
		{cpu_req.data_high, cpu_req.data_low} <= w;
		if (s)
			cpu_req.store_program_instruction <= 1'h1;
		else
			cpu_req.lpm <= 1'h1;
		@(posedge clock);
		cpu_req.store_program_instruction <= 1'h0;
		cpu_req.lpm <= 1'h0;
	endtask

	// Bounded waits; a missing start or readback pulse shows as a compare
	// Pulses stand one cycle from the launching edge, so look before waiting
	task automatic wstart(input logic e);
		logic seen = 1'h0;
		repeat (8)
		begin
			#1 if (flash_op.start === 1'h1) seen = 1'h1;
			@(posedge clock);
		end
		#1 `CHK(seen, e)
	endtask
	task automatic wlpm(input logic e);
		logic seen = 1'h0;
		repeat (4)
		begin
			#1 if (lpm_valid === 1'h1) seen = 1'h1;
			if (seen) break;
			@(posedge clock);
		end
		`CHK(seen, e)
	endtask
	task automatic wdone;
		repeat (100)
		begin
			@(posedge clock);
			#1 if (flash_done === 1'h1) break;
		end
		@(posedge clock);
		#1;
	endtask
	task automatic bufchk(input logic [4:0] i, input logic [15:0] e);
		buf_sel <= i;
		repeat (2) @(posedge clock);
		#1 `CHK(flash_buf_data, e)
	endtask

	task automatic t_reset(input logic f, input logic [15:0] vec);
		boot_reset_fuse <= f;
		srst <= 1'h1;
		repeat (4) @(posedge clock);
		srst <= 1'h0;
		@(posedge clock);
		#1 `CHK(reset_vector, vec)
		rd(CTRL);
		`CHK(d, fspc_pkg::CTRL_RESET)
		rd(8'h05);
		`CHK(d, fspc_pkg::UNMAPPED_READ)
		bufchk(5'h00, 16'hFFFF);
	endtask

	// Concurrent section: erase, out-of-order fill, write, re-enable
	task automatic t_conc;
		wr(CTRL, 8'(fspc_pkg::CMD_ERASE));
		ins(1'h1, 16'h0100, 16'h0000);
		wstart(1'h1);
		`CHK(flash_op.kind, fspc_pkg::OP_ERASE)
		`CHK(flash_op.page, 16'h0004)
		`CHK({section_blocked, cpu_stall}, 2'h2)
		cpu_req.pointer <= 16'h3FC0;
		rd(CTRL);
		`CHK(d, 8'h43)
		`CHK(flash_op.page, 16'h0004)
		wdone;
		rd(CTRL);
		`CHK(d, 8'h40)
		wr(CTRL, 8'(fspc_pkg::CMD_STORE));
		ins(1'h1, 16'h0107, 16'hA55A);
		#1 `CHK(section_blocked, 1'h0)
		wr(CTRL, 8'(fspc_pkg::CMD_STORE));
		ins(1'h1, 16'h0102, 16'h1234);
		bufchk(5'h03, 16'hA55A);
		bufchk(5'h01, 16'h1234);
		wr(CTRL, 8'(fspc_pkg::CMD_WRITE));
		ins(1'h1, 16'h0100, 16'h0000);
		wstart(1'h1);
		`CHK({flash_op.kind, flash_op.page}, {fspc_pkg::OP_WRITE, 16'h0004})
		wr(CTRL, 8'(fspc_pkg::CMD_REENABLE));
		ins(1'h1, 16'h0000, 16'h0000);
		#1 `CHK(section_blocked, 1'h1)
		wdone;
		bufchk(5'h03, 16'hFFFF);
		wr(CTRL, 8'(fspc_pkg::CMD_REENABLE));
		ins(1'h1, 16'h0000, 16'h0000);
		@(posedge clock);
		#1 `CHK(section_blocked, 1'h0)
	endtask

	task automatic t_block;
		wr(CTRL, 8'(fspc_pkg::CMD_ERASE));
		ins(1'h1, 16'h1840, 16'h0000);
		wstart(1'h1);
		`CHK({cpu_stall, section_blocked}, 2'h2)
		wdone;
		`CHK(cpu_stall, 1'h0)
	endtask

	// Fuse and lock readback, then a lock store with a prompt array
	task automatic t_lock;
		logic [15:0] ptr [3] = '{16'h0000, 16'h0001, 16'h0003};
		logic [7:0] exp [3];
		exp = '{fuse_low, lock_bits, fuse_high};
		for (int i = 0; i < 3; i++)
		begin
			wr(CTRL, 8'(fspc_pkg::CMD_LOCK));
			ins(1'h0, ptr[i], 16'h0000);
			wlpm(1'h1);
			`CHK(lpm_data, exp[i])
		end
		// A load in the fourth armed cycle is past the readback window
		wr(CTRL, 8'(fspc_pkg::CMD_LOCK));
		repeat (3) @(posedge clock);
		ins(1'h0, 16'h0001, 16'h0000);
		wlpm(1'h0);
		latency <= 8'h02;
		wr(CTRL, 8'(fspc_pkg::CMD_LOCK));
		ins(1'h1, 16'hFFFF, 16'h77C3);
		wstart(1'h1);
		`CHK({flash_op.kind, flash_op.lock_data}, {fspc_pkg::OP_LOCK, 8'hC3})
		rd(CTRL);
		`CHK(d, 8'h00)
		latency <= 8'h14;
	endtask

	task automatic t_refuse;
		ins(1'h1, 16'h0100, 16'h0000);
		wstart(1'h0);
		wr(CTRL, 8'h07);
		ins(1'h1, 16'h0100, 16'h0000);
		wstart(1'h0);
		rd(CTRL);
		`CHK(d, 8'h00)
		eeprom_busy <= 1'h1;
		wr(CTRL, 8'(fspc_pkg::CMD_ERASE));
		ins(1'h1, 16'h0100, 16'h0000);
		wstart(1'h0);
		wr(CTRL, 8'(fspc_pkg::CMD_LOCK));
		ins(1'h0, 16'h0001, 16'h0000);
		wlpm(1'h0);
		eeprom_busy <= 1'h0;
		// Last cycle of the window accepted, the one after refused
		wr(CTRL, 8'(fspc_pkg::CMD_STORE));
		repeat (3) @(posedge clock);
		ins(1'h1, 16'h0104, 16'hBEEF);
		bufchk(5'h02, 16'hBEEF);
		wr(CTRL, 8'(fspc_pkg::CMD_STORE));
		repeat (4) @(posedge clock);
		ins(1'h1, 16'h0106, 16'hBEEF);
		bufchk(5'h03, 16'hFFFF);
		wr(CTRL, 8'(fspc_pkg::CMD_STORE));
		ins(1'h1, 16'h010A, 16'h0A0B);
		wr(CTRL, 8'h10);
		bufchk(5'h05, 16'hFFFF);
	endtask

	task automatic t_irq;
		global_int_flag <= 1'h1;
		wr(CTRL, 8'h80);
		#1 `CHK(ready_irq, 1'h1)
		wr(CTRL, 8'h81);
		#1 `CHK(ready_irq, 1'h0)
		repeat (5) @(posedge clock);
		#1 `CHK(ready_irq, 1'h1)
		global_int_flag <= 1'h0;
		@(posedge clock);
		#1 `CHK(ready_irq, 1'h0)
		wr(CTRL, 8'h00);
	endtask

	task automatic report_and_stop;
		$display("checked %0d miscompares %0d", checked, miscompares);
		if (miscompares == 0 && checked > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	// Main sequence
	initial
	begin
		t_reset(1'h1, fspc_pkg::APP_RESET_ADDR);
		t_conc;
		t_block;
		t_lock;
		t_refuse;
		t_irq;
		t_reset(1'h0, 16'h0C00);
		report_and_stop;
	end

	// Watchdog, far beyond the few hundred cycles the tests need
	initial
	begin
		#(40 * 20000);
		miscompares++;
		report_and_stop;
	end
endmodule // testbench
